/* File: strobe_proc_pkg.sv */
// Constants, types and helpers shared by the strobe processor files
// What this block does
// - Expose instruction port, four data registers, control register and interrupt requests.
// - Timer overflow events are the only timing input, used for waits and counts.
// - Two modes: immediate strobe execution and stored program execution.
// - Immediate strobes go to the radio at once and also control the processor.
// - Program mode runs stored instructions of the basic instruction types.
// - Non-immediate port writes store into memory; reads return current instruction; reset value C0.
// - Instructions are one byte, fetched from a 24-location memory.
// - Internal write pointer marks the next location, cleared to zero on reset.
// - Each store advances the pointer by one, stopping at the final location.
// - First store after clearing goes to location zero; execution starts at zero.
// - Writing the immediate halt strobe clears the write pointer.
// - Executing the program halt strobe clears the write pointer.
// - Reset fills every memory location with the no-operation opcode C0.
// - Immediate strobes are still accepted while a program runs.
// - The immediate run strobe starts execution after memory is filled.
// - While an immediate strobe executes, a port read returns C0.
// - An immediate strobe runs first; the interrupted program instruction completes afterwards.
// - Undefined opcodes execute as a no-operation but, unlike C0, send no strobe to the radio.
package strobe_proc_pkg;
   localparam int MEM_DEPTH = 24;
   localparam int PTR_W = 5;
   localparam logic [4:0] LAST_LOC = 5'h17;
   localparam logic [7:0] INSTR_RESET = 8'hC0;
   localparam logic [7:0] NOP_OPCODE = 8'hC0;
   localparam logic [7:0] IMM_HALT = 8'hFF;
   localparam logic [7:0] IMM_RUN = 8'hFE;
   localparam logic [7:0] PROG_HALT = 8'hDF;
   localparam logic [2:0] CLASS_IMM = 3'h7;
   localparam logic [2:0] CLASS_STROBE = 3'h6;
   localparam logic [2:0] CLASS_WAIT = 3'h4;
   localparam logic [7:0] OP_WAITX = 8'hBB;
   localparam logic [7:0] OP_INT = 8'hB9;
   localparam logic [7:0] OP_INCY = 8'hBD;
   localparam logic [7:0] OP_DECY = 8'hBE;
   localparam logic [7:0] OP_DECZ = 8'hBF;
   localparam logic [2:0] REG_X = 3'h0;
   localparam logic [2:0] REG_Y = 3'h1;
   localparam logic [2:0] REG_Z = 3'h2;
   localparam logic [2:0] REG_T = 3'h3;
   localparam logic [2:0] REG_CTRL = 3'h4;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] T_RESET = 8'hFF;
   localparam logic [7:0] T_HOLD = 8'hFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT} seq_state_t;

   function automatic logic is_immediate(input logic [7:0] op);
      return op[7:5] == CLASS_IMM;
   endfunction
endpackage

/* File: imem_if.sv */
// Connection between the sequencer and its instruction memory
`timescale 1ns/1ps
interface imem_if;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   modport mem_side (input wr_en, input wr_addr, input wr_data, input rd_addr,
      output rd_data);
   modport user_side (output wr_en, output wr_addr, output wr_data, output rd_addr,
      input rd_data);
endinterface

/* File: strobe_imem.sv */
// Instruction memory with reset fill and registered read
`timescale 1ns/1ps
module strobe_imem (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Memory port
   imem_if.mem_side bus
);
   logic [7:0] mem_reg [strobe_proc_pkg::MEM_DEPTH];
   logic [7:0] rd_reg;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < strobe_proc_pkg::MEM_DEPTH; i++) begin
            mem_reg[i] <= strobe_proc_pkg::NOP_OPCODE;
         end
         rd_reg <= strobe_proc_pkg::NOP_OPCODE;
      end else begin
         if (bus.wr_en) begin
            mem_reg[bus.wr_addr] <= bus.wr_data;
         end
         rd_reg <= mem_reg[bus.rd_addr];
      end
   end

   assign bus.rd_data = rd_reg;

   a_mem_store: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      bus.wr_en |=> mem_reg[$past(bus.wr_addr)] == $past(bus.wr_data))
      else $error("stored byte not found in memory");
   a_mem_fill: assert property (@(posedge i_mclk)
      $fell(i_sys_rst) |-> mem_reg[0] == strobe_proc_pkg::NOP_OPCODE
         && mem_reg[strobe_proc_pkg::MEM_DEPTH - 1] == strobe_proc_pkg::NOP_OPCODE)
      else $error("memory not filled with no-op after reset");
endmodule

/* File: strobe_processor.sv */
// Command strobe processor: instruction port, write pointer and sequencer
`timescale 1ns/1ps
module strobe_processor (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Instruction port
   input wire logic i_port_wr,
   input wire logic [7:0] i_port_wdata,
   output logic [7:0] o_port_rdata,
   // Data and control registers
   input wire logic i_rf_wr,
   input wire logic [2:0] i_rf_addr,
   input wire logic [7:0] i_rf_wdata,
   output logic [7:0] o_rf_rdata,
   // Timer events
   input wire logic i_mac_ovf,
   // Radio strobes
   output logic o_strobe_vld,
   output logic [7:0] o_strobe_code,
   // Interrupt requests
   output logic o_irq_stop,
   output logic o_irq_wait,
   output logic o_irq_int
);
   imem_if imem_bus();

   strobe_imem u_imem (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .bus(imem_bus.mem_side)
   );

   strobe_proc_pkg::seq_state_t state_reg, state_next;
   logic [4:0] pc_reg, pc_next;
   logic [4:0] wptr_reg, wptr_next;
   logic [7:0] cur_reg, cur_next;
   logic [7:0] wcnt_reg, wcnt_next;
   logic [7:0] x_reg, x_next, y_reg, y_next, z_reg, z_next, t_reg, t_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] strobe_reg, strobe_next;
   logic strobe_vld_reg, strobe_vld_next;
   logic imm_busy_reg, imm_busy_next;
   logic irq_stop_reg, irq_stop_next, irq_wait_reg, irq_wait_next;
   logic irq_int_reg, irq_int_next;
   logic imm_wr, store_wr, running;
   logic [7:0] op;

   assign imm_wr = i_port_wr && strobe_proc_pkg::is_immediate(i_port_wdata);
   assign store_wr = i_port_wr && !strobe_proc_pkg::is_immediate(i_port_wdata);
   assign running = state_reg != strobe_proc_pkg::ST_IDLE;
   assign op = imem_bus.rd_data;

   // Stores go to the write pointer; reads follow the program counter
   assign imem_bus.wr_en = store_wr;
   assign imem_bus.wr_addr = wptr_reg;
   assign imem_bus.wr_data = i_port_wdata;
   assign imem_bus.rd_addr = pc_reg;

   always_comb begin
      logic advance;
      logic stop;
      advance = 1'b0;
      stop = 1'b0;
      state_next = state_reg;
      pc_next = pc_reg;
      wptr_next = wptr_reg;
      cur_next = cur_reg;
      wcnt_next = wcnt_reg;
      x_next = x_reg;
      y_next = y_reg;
      z_next = z_reg;
      t_next = t_reg;
      ctrl_next = ctrl_reg;
      strobe_next = strobe_reg;
      strobe_vld_next = 1'b0;
      imm_busy_next = imm_wr;
      irq_stop_next = 1'b0;
      irq_wait_next = 1'b0;
      irq_int_next = 1'b0;
      if (store_wr && wptr_reg != strobe_proc_pkg::LAST_LOC) begin
         wptr_next = wptr_reg + 5'h01;
      end
      if (imm_wr) begin
         strobe_next = i_port_wdata;
         strobe_vld_next = 1'b1;
      end else begin
         // Program holds still for the cycle of an immediate strobe
         unique case (state_reg)
            strobe_proc_pkg::ST_IDLE: begin
               cur_next = strobe_proc_pkg::INSTR_RESET;
            end
            strobe_proc_pkg::ST_FETCH: begin
               state_next = strobe_proc_pkg::ST_EXEC;
            end
            strobe_proc_pkg::ST_EXEC: begin
               cur_next = op;
               advance = 1'b1;
               if (op == strobe_proc_pkg::PROG_HALT) begin
                  strobe_next = op;
                  strobe_vld_next = 1'b1;
                  wptr_next = '0;
                  advance = 1'b0;
                  stop = 1'b1;
               end else if (op[7:5] == strobe_proc_pkg::CLASS_STROBE) begin
                  strobe_next = op;
                  strobe_vld_next = 1'b1;
               end else if (op[7:5] == strobe_proc_pkg::CLASS_WAIT) begin
                  wcnt_next = {3'h0, op[4:0]};
                  state_next = strobe_proc_pkg::ST_WAIT;
                  advance = 1'b0;
               end else if (op == strobe_proc_pkg::OP_WAITX) begin
                  wcnt_next = x_reg;
                  state_next = strobe_proc_pkg::ST_WAIT;
                  advance = 1'b0;
               end else if (op == strobe_proc_pkg::OP_INT) begin
                  irq_int_next = 1'b1;
               end else if (op == strobe_proc_pkg::OP_INCY) begin
                  y_next = y_reg + 8'h01;
               end else if (op == strobe_proc_pkg::OP_DECY) begin
                  y_next = y_reg - 8'h01;
               end else if (op == strobe_proc_pkg::OP_DECZ) begin
                  z_next = z_reg - 8'h01;
               end
               // Other opcodes pass as a no-operation
            end
            strobe_proc_pkg::ST_WAIT: begin
               if (wcnt_reg == 8'h00) begin
                  irq_wait_next = 1'b1;
                  advance = 1'b1;
               end else if (i_mac_ovf) begin
                  wcnt_next = wcnt_reg - 8'h01;
               end
            end
         endcase
         if (advance) begin
            if (pc_reg == strobe_proc_pkg::LAST_LOC) begin
               stop = 1'b1;
            end else begin
               pc_next = pc_reg + 5'h01;
               state_next = strobe_proc_pkg::ST_FETCH;
            end
         end
      end
      // Overflow countdown halts the program at zero
      if (running && i_mac_ovf && t_reg != strobe_proc_pkg::T_HOLD) begin
         t_next = t_reg - 8'h01;
      end
      if (running && t_reg == 8'h00) begin
         stop = 1'b1;
      end
      if (imm_wr && i_port_wdata == strobe_proc_pkg::IMM_HALT) begin
         wptr_next = '0;
         stop = running;
         if (!running) begin
            state_next = strobe_proc_pkg::ST_IDLE;
         end
      end
      if (stop) begin
         state_next = strobe_proc_pkg::ST_IDLE;
         irq_stop_next = 1'b1;
      end
      if (imm_wr && i_port_wdata == strobe_proc_pkg::IMM_RUN) begin
         pc_next = '0;
         state_next = strobe_proc_pkg::ST_FETCH;
      end
      if (i_rf_wr) begin
         unique case (i_rf_addr)
            strobe_proc_pkg::REG_X: x_next = i_rf_wdata;
            strobe_proc_pkg::REG_Y: y_next = i_rf_wdata;
            strobe_proc_pkg::REG_Z: z_next = i_rf_wdata;
            strobe_proc_pkg::REG_T: t_next = i_rf_wdata;
            strobe_proc_pkg::REG_CTRL: ctrl_next = i_rf_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg <= strobe_proc_pkg::ST_IDLE;
         pc_reg <= '0;
         wptr_reg <= '0;
         cur_reg <= strobe_proc_pkg::INSTR_RESET;
         wcnt_reg <= 8'h00;
         x_reg <= strobe_proc_pkg::DATA_RESET;
         y_reg <= strobe_proc_pkg::DATA_RESET;
         z_reg <= strobe_proc_pkg::DATA_RESET;
         t_reg <= strobe_proc_pkg::T_RESET;
         ctrl_reg <= strobe_proc_pkg::CTRL_RESET;
         strobe_reg <= strobe_proc_pkg::NOP_OPCODE;
         strobe_vld_reg <= 1'b0;
         imm_busy_reg <= 1'b0;
         irq_stop_reg <= 1'b0;
         irq_wait_reg <= 1'b0;
         irq_int_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         wptr_reg <= wptr_next;
         cur_reg <= cur_next;
         wcnt_reg <= wcnt_next;
         x_reg <= x_next;
         y_reg <= y_next;
         z_reg <= z_next;
         t_reg <= t_next;
         ctrl_reg <= ctrl_next;
         strobe_reg <= strobe_next;
         strobe_vld_reg <= strobe_vld_next;
         imm_busy_reg <= imm_busy_next;
         irq_stop_reg <= irq_stop_next;
         irq_wait_reg <= irq_wait_next;
         irq_int_reg <= irq_int_next;
      end
   end

   assign o_port_rdata = imm_busy_reg ? strobe_proc_pkg::NOP_OPCODE : cur_reg;
   assign o_strobe_vld = strobe_vld_reg;
   assign o_strobe_code = strobe_reg;
   assign o_irq_stop = irq_stop_reg;
   assign o_irq_wait = irq_wait_reg;
   assign o_irq_int = irq_int_reg;

   always_comb begin
      unique case (i_rf_addr)
         strobe_proc_pkg::REG_X: o_rf_rdata = x_reg;
         strobe_proc_pkg::REG_Y: o_rf_rdata = y_reg;
         strobe_proc_pkg::REG_Z: o_rf_rdata = z_reg;
         strobe_proc_pkg::REG_T: o_rf_rdata = t_reg;
         strobe_proc_pkg::REG_CTRL: o_rf_rdata = {ctrl_reg[7:1], running};
         default: o_rf_rdata = 8'h00;
      endcase
   end

   sequence seq_imm_write(logic [7:0] code);
      i_port_wr && i_port_wdata == code;
   endsequence
   sequence seq_store_write;
      i_port_wr && !strobe_proc_pkg::is_immediate(i_port_wdata);
   endsequence

   a_ptr_advance: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      seq_store_write ##0 (wptr_reg != strobe_proc_pkg::LAST_LOC)
         ##0 (!imm_wr) |=> wptr_reg == $past(wptr_reg) + 5'h01 || state_reg == $past(state_reg)
         && $past(state_reg) == strobe_proc_pkg::ST_IDLE && wptr_reg == 5'h00)
      else $error("write pointer did not advance by one");
   a_ptr_saturate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      seq_store_write ##0 (wptr_reg == strobe_proc_pkg::LAST_LOC)
         ##0 (state_reg == strobe_proc_pkg::ST_IDLE) |=> wptr_reg == strobe_proc_pkg::LAST_LOC)
      else $error("write pointer moved past the final location");
   a_halt_clears_ptr: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      seq_imm_write(strobe_proc_pkg::IMM_HALT) |=> wptr_reg == 5'h00
         && state_reg == strobe_proc_pkg::ST_IDLE)
      else $error("immediate halt left pointer or sequencer running");
   a_imm_forward: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      imm_wr |=> o_strobe_vld && o_strobe_code == $past(i_port_wdata)
         && o_port_rdata == strobe_proc_pkg::NOP_OPCODE)
      else $error("immediate strobe not forwarded or readback wrong");
   a_run_from_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      seq_imm_write(strobe_proc_pkg::IMM_RUN) |=> state_reg == strobe_proc_pkg::ST_FETCH
         && pc_reg == 5'h00 ##1 state_reg == strobe_proc_pkg::ST_EXEC || imm_busy_reg)
      else $error("run strobe did not start at location zero");
   a_prog_halt: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == strobe_proc_pkg::ST_EXEC && op == strobe_proc_pkg::PROG_HALT && !imm_wr
         |=> wptr_reg == 5'h00 && state_reg == strobe_proc_pkg::ST_IDLE && o_irq_stop)
      else $error("program halt did not clear pointer and stop");
   a_imm_preempts: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == strobe_proc_pkg::ST_EXEC && imm_wr && !stop_cond()
         |=> state_reg == strobe_proc_pkg::ST_EXEC && $stable(pc_reg))
      else $error("program instruction not held behind immediate strobe");
   a_wait_overflow: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == strobe_proc_pkg::ST_WAIT && wcnt_reg != 8'h00 && i_mac_ovf && !imm_wr
         |=> wcnt_reg == $past(wcnt_reg) - 8'h01)
      else $error("wait count did not follow overflow");

   function automatic logic stop_cond();
      return (t_reg == 8'h00) || (i_port_wdata == strobe_proc_pkg::IMM_HALT)
         || (i_port_wdata == strobe_proc_pkg::IMM_RUN);
   endfunction
endmodule

/* File: cpu_model.sv */
// Behavioural CPU driving the instruction port, data registers and timer events
`timescale 1ns/1ps
module cpu_model (
   // Clock
   input wire logic i_mclk,
   // Instruction port
   output logic o_port_wr,
   output logic [7:0] o_port_wdata,
   // Data registers
   output logic o_rf_wr,
   output logic [2:0] o_rf_addr,
   output logic [7:0] o_rf_wdata,
   // Timer events
   output logic o_mac_ovf
);
   initial begin
      o_port_wr = 1'b0;
      o_port_wdata = 8'h00;
      o_rf_wr = 1'b0;
      o_rf_addr = 3'h0;
      o_rf_wdata = 8'h00;
      o_mac_ovf = 1'b0;
   end

   // Programs are stored whole before the run strobe, never while running
   task automatic port_write(input logic [7:0] data);
      @(negedge i_mclk);
      o_port_wr = 1'b1;
      o_port_wdata = data;
      @(negedge i_mclk);
      o_port_wr = 1'b0;
      o_port_wdata = ~data;
   endtask

   task automatic rf_write(input logic [2:0] addr, input logic [7:0] data);
      @(negedge i_mclk);
      o_rf_wr = 1'b1;
      o_rf_addr = addr;
      o_rf_wdata = data;
      @(negedge i_mclk);
      o_rf_wr = 1'b0;
      o_rf_wdata = ~data;
   endtask

   // Point the register read mux without writing; returns once it has settled
   task automatic rf_select(input logic [2:0] addr);
      @(negedge i_mclk);
      o_rf_addr = addr;
      @(negedge i_mclk);
   endtask

   task automatic ovf_pulse();
      @(negedge i_mclk);
      o_mac_ovf = 1'b1;
      @(negedge i_mclk);
      o_mac_ovf = 1'b0;
   endtask
endmodule

/* File: test_radio_strobe_processor_imem.sv */
// Self-checking testbench for the strobe processor front end
`timescale 1ns/1ps
module test_radio_strobe_processor_imem;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic port_wr, rf_wr, mac_ovf, strobe_vld, irq_stop, irq_wait, irq_int;
   logic [7:0] port_wdata, rf_wdata, port_rdata, rf_rdata, strobe_code;
   logic [2:0] rf_addr;
   logic [7:0] codes[$];
   logic [7:0] fill_exp[$];
   int stop_count = 0;
   int wait_count = 0;
   int int_count = 0;
   int fail_count = 0;
   int n_compared = 0;

   always #2.5 i_mclk = ~i_mclk;

   cpu_model cpu_model_inst (.i_mclk(i_mclk), .o_port_wr(port_wr), .o_port_wdata(port_wdata),
      .o_rf_wr(rf_wr), .o_rf_addr(rf_addr), .o_rf_wdata(rf_wdata), .o_mac_ovf(mac_ovf));

   strobe_processor strobe_processor_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_port_wr(port_wr), .i_port_wdata(port_wdata), .o_port_rdata(port_rdata),
      .i_rf_wr(rf_wr), .i_rf_addr(rf_addr), .i_rf_wdata(rf_wdata), .o_rf_rdata(rf_rdata),
      .i_mac_ovf(mac_ovf), .o_strobe_vld(strobe_vld), .o_strobe_code(strobe_code),
      .o_irq_stop(irq_stop), .o_irq_wait(irq_wait), .o_irq_int(irq_int));

   // Record every strobe sent to the radio and count interrupt pulses
   always @(posedge i_mclk) begin
      if (strobe_vld === 1'b1) begin
         codes.push_back(strobe_code);
      end
      if (irq_stop === 1'b1) begin
         stop_count++;
      end
      if (irq_wait === 1'b1) begin
         wait_count++;
      end
      if (irq_int === 1'b1) begin
         int_count++;
      end
   end

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_seq(input logic [7:0] exp[$]);
      check_val(8'(codes.size()), 8'(exp.size()));
      foreach (exp[i]) begin
         check_val(codes[i], exp[i]);
      end
   endtask

   task automatic wait_stop();
      int start;
      start = stop_count;
      for (int i = 0; i < 300 && stop_count == start; i++) begin
         @(negedge i_mclk);
      end
      check_val(8'(stop_count - start), 8'h01);
   endtask

   task automatic load(input logic [7:0] prog[$]);
      cpu_model_inst.port_write(strobe_proc_pkg::IMM_HALT);
      foreach (prog[i]) begin
         cpu_model_inst.port_write(prog[i]);
      end
   endtask

   task automatic run_to_stop();
      codes.delete();
      cpu_model_inst.port_write(strobe_proc_pkg::IMM_RUN);
      wait_stop();
   endtask

   task automatic t_reset();
      logic [7:0] exp[$];
      check_val(port_rdata, 8'hC0);
      exp.push_back(strobe_proc_pkg::IMM_RUN);
      for (int i = 0; i < 24; i++) begin
         exp.push_back(8'hC0);
      end
      run_to_stop();
      check_seq(exp);
   endtask

   task automatic t_immediate();
      cpu_model_inst.port_write(8'hE5);
      check_val({7'h00, strobe_vld}, 8'h01);
      check_val(strobe_code, 8'hE5);
      check_val(port_rdata, 8'hC0);
   endtask

   task automatic t_fill();
      logic [7:0] prog[$];
      fill_exp.push_back(strobe_proc_pkg::IMM_RUN);
      for (int i = 0; i < 23; i++) begin
         prog.push_back(8'hC1 + 8'(i));
         fill_exp.push_back(8'hC1 + 8'(i));
      end
      prog.push_back(8'hD0);
      prog.push_back(8'hD5);
      fill_exp.push_back(8'hD5);
      load(prog);
      run_to_stop();
      check_seq(fill_exp);
   endtask

   task automatic t_imm_in_prog();
      logic [7:0] rest[$];
      int hits;
      hits = 0;
      load('{8'hC1, 8'hC2, 8'hC3, 8'hC4});
      codes.delete();
      cpu_model_inst.port_write(strobe_proc_pkg::IMM_RUN);
      // Let the first instruction execute so the readback has something to hide
      repeat (2) @(negedge i_mclk);
      cpu_model_inst.port_write(8'hE3);
      check_val(port_rdata, 8'hC0);
      wait_stop();
      foreach (codes[i]) begin
         if (codes[i] === 8'hE3) begin
            hits++;
         end else begin
            rest.push_back(codes[i]);
         end
      end
      check_val(8'(hits), 8'h01);
      check_val(codes[2], 8'hE3);
      codes = rest;
      check_seq(fill_exp);
   endtask

   task automatic t_prog_halt();
      load('{8'hC3, strobe_proc_pkg::PROG_HALT});
      run_to_stop();
      cpu_model_inst.port_write(8'hC7);
      run_to_stop();
      check_val(codes[1], 8'hC7);
   endtask

   task automatic t_wait();
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_T, 8'hFF);
      check_val(rf_rdata, 8'hFF);
      load('{8'h84});
      codes.delete();
      cpu_model_inst.port_write(strobe_proc_pkg::IMM_RUN);
      repeat (6) @(negedge i_mclk);
      check_val(port_rdata, 8'h84);
      repeat (3) cpu_model_inst.ovf_pulse();
      check_val(8'(wait_count), 8'h00);
      cpu_model_inst.ovf_pulse();
      repeat (2) @(negedge i_mclk);
      check_val(8'(wait_count), 8'h01);
      wait_stop();
   endtask

   task automatic t_regs();
      int w0;
      int i0;
      w0 = wait_count;
      i0 = int_count;
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_X, 8'h5A);
      check_val(rf_rdata, 8'h5A);
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_Y, 8'h3C);
      check_val(rf_rdata, 8'h3C);
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_Z, 8'hA5);
      check_val(rf_rdata, 8'hA5);
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_CTRL, 8'h82);
      check_val(rf_rdata, 8'h82);
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_X, 8'h00);
      load('{8'hBD, 8'hBD, 8'hBE, 8'hBF, 8'hBB, 8'hB9, strobe_proc_pkg::PROG_HALT});
      run_to_stop();
      check_val(8'(int_count - i0), 8'h01);
      check_val(8'(wait_count - w0), 8'h01);
      cpu_model_inst.rf_select(strobe_proc_pkg::REG_Y);
      check_val(rf_rdata, 8'h3D);
      cpu_model_inst.rf_select(strobe_proc_pkg::REG_Z);
      check_val(rf_rdata, 8'hA4);
      // Countdown of two overflows ends a long wait early
      cpu_model_inst.rf_write(strobe_proc_pkg::REG_T, 8'h02);
      load('{8'h9F});
      codes.delete();
      cpu_model_inst.port_write(strobe_proc_pkg::IMM_RUN);
      repeat (2) cpu_model_inst.ovf_pulse();
      wait_stop();
      check_val(rf_rdata, 8'h00);
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end

   initial begin
      repeat (3) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      t_reset();
      t_immediate();
      t_fill();
      t_imm_in_prog();
      t_prog_halt();
      t_wait();
      t_regs();
      print_verdict();
   end
endmodule
